// file: src/dds_core.v
// Two-channel DDS core with shared-address programming and output FIFO
`timescale 1ns/1ns
`default_nettype none
`include "dds_consts.vh"

////////////////////////////////////////////////////////////////////////////
// Output sample FIFO
module dds_fifo #(
    parameter WIDTH = 20,
    parameter DEPTH = `DDS_FIFO_DEPTH,
    parameter AW = `DDS_FIFO_AW
) (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wptr_r;
    reg [AW-1:0] rptr_r;
    reg [AW:0] cnt_r;
    wire push;
    wire pop;

    assign in_ready = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign out_data = mem_r[rptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge clk)
    begin
        if (push)
        begin
            mem_r[wptr_r] <= in_data;
        end
    end

    always @(posedge clk)
    begin
        if (reset)
        begin
            wptr_r <= {AW{1'b0}};
            rptr_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (pop)
            begin
                rptr_r <= rptr_r + 1'b1;
            end
            if (push && !pop)
            begin
                cnt_r <= cnt_r + 1'b1;
            end
            else if (pop && !push)
            begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule // dds_fifo

////////////////////////////////////////////////////////////////////////////
module dds_core (
    // Clock and reset
    input wire CLK,
    input wire RESET,
    // Register port
    input wire [7:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    input wire REG_WE,
    input wire REG_RE,
    output wire [31:0] REG_RDATA,
    // Update strobe and profile inputs
    input wire IO_UPDATE,
    input wire [3:0] PROFILE,
    input wire [2:0] SDIO_RAMP_IN,
    output wire SYNC_CLK,
    // Status
    output wire MODE_ILLEGAL,
    output wire [1:0] AMPLITUDE_RAMP,
    output wire [1:0] SERIAL_MODE,
    // DAC sample stream
    output wire [9:0] DAC0_CODE,
    output wire [9:0] DAC1_CODE,
    output wire DAC_VALID,
    input wire DAC_READY
);
    integer i;
    integer j;
    reg [1:0] chan_en_r;
    reg [1:0] ramp_src_r;
    reg [1:0] sio_mode_r;
    reg [23:0] cfr_r [0:1];
    reg [31:0] ftw_s_r [0:1];
    reg [31:0] ftw_a_r [0:1];
    reg [13:0] pow_s_r [0:1];
    reg [13:0] pow_a_r [0:1];
    reg [13:0] pow_d_r [0:1];
    reg [31:0] acc_r [0:1];
    reg [13:0] ph_r [0:1];
    reg pipe_vld_r;
    reg [1:0] sync_cnt_r;
    reg [3:0] prof_r;
    reg illegal_r;
    reg [1:0] ramp_r;
    reg [31:0] rdata_r;
    reg [31:0] rdata_nxt;
    reg [1:0] ramp_nxt;
    wire upd_take;
    wire go;
    wire rch;
    wire [19:0] push_data;

    // Cosine converter: offset-binary parabolic approximation
    function [9:0] cos_code;
        input [13:0] ph;
        reg [13:0] c;
        reg [13:0] u;
        reg [26:0] p;
        reg [8:0] y;
        begin
            c = ph + `DDS_QUARTER;
            u = 14'h2000 - {1'b0, c[12:0]};
            p = c[12:0] * u;
            y = p[24] ? 9'h1FF : p[23:15];
            cos_code = c[13] ? (`DDS_MID - {1'b0, y}) : (`DDS_MID + {1'b0, y});
        end
    endfunction

    // Legality of one channel's mode given the other channel
    function chan_ok;
        input [23:0] c;
        input [23:0] o;
        input [1:0] src;
        reg st;
        reg ost;
        reg m;
        reg om;
        reg [1:0] lv;
        reg [1:0] olv;
        reg base;
        begin
            st = c[`DDS_CF_KIND_HI:`DDS_CF_KIND_LO] == `DDS_KIND_NONE;
            ost = o[`DDS_CF_KIND_HI:`DDS_CF_KIND_LO] == `DDS_KIND_NONE;
            m = !st && !c[`DDS_CF_SWEEP];
            om = !ost && !o[`DDS_CF_SWEEP];
            lv = c[`DDS_CF_LVL_HI:`DDS_CF_LVL_LO];
            olv = o[`DDS_CF_LVL_HI:`DDS_CF_LVL_LO];
            base = !m || (lv <= `DDS_LVL_4) || ost;
            if (st || !c[`DDS_CF_RAMP])
            begin
                // ramp in single tone always allowed
                chan_ok = st || base;
            end
            else if (c[`DDS_CF_KIND_HI:`DDS_CF_KIND_LO] == `DDS_KIND_AMP)
            begin
                chan_ok = 1'b0;
            end
            else
            begin
                case (src)
                    `DDS_SRC_P23:
                        chan_ok = (m && lv == `DDS_LVL_2 && ost) ||
                            (!m && (ost || !om));
                    `DDS_SRC_P3:
                        chan_ok = m && lv == `DDS_LVL_8 && ost;
                    `DDS_SRC_SDIO:
                        chan_ok = m && (ost || (lv <= `DDS_LVL_4 && om &&
                            olv == lv));
                    default:
                        chan_ok = 1'b0;
                endcase
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Sync clock and sampled strobes
    // quarter-rate sync clock
    assign SYNC_CLK = sync_cnt_r[1];
    assign upd_take = IO_UPDATE && (sync_cnt_r == `DDS_SYNC_SAMPLE);

    always @(posedge CLK)
    begin
        if (RESET)
        begin
            sync_cnt_r <= `DDS_SYNC_RST;
            prof_r <= 4'h0;
        end
        else
        begin
            sync_cnt_r <= sync_cnt_r + 2'h1;
            // profiles sampled at the sync rising edge
            if (sync_cnt_r == `DDS_SYNC_SAMPLE)
            begin
                prof_r <= PROFILE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes and staging
    always @(posedge CLK)
    begin
        if (RESET)
        begin
            chan_en_r <= `DDS_CS_EN_RST;
            ramp_src_r <= `DDS_CS_SRC_RST;
            sio_mode_r <= `DDS_CS_SIO_RST;
            for (i = 0; i < 2; i = i + 1)
            begin
                cfr_r[i] <= `DDS_CF_RST;
                ftw_s_r[i] <= `DDS_FTW_RST;
                ftw_a_r[i] <= `DDS_FTW_RST;
                pow_s_r[i] <= `DDS_POW_RST;
                pow_a_r[i] <= `DDS_POW_RST;
            end
        end
        else
        begin
            if (REG_WE && REG_ADDR == `DDS_ADDR_CSEL)
            begin
                chan_en_r <= REG_WDATA[`DDS_CS_EN_HI:`DDS_CS_EN_LO];
                ramp_src_r <= REG_WDATA[`DDS_CS_SRC_HI:`DDS_CS_SRC_LO];
                sio_mode_r <= REG_WDATA[`DDS_CS_SIO_HI:`DDS_CS_SIO_LO];
            end
            for (i = 0; i < 2; i = i + 1)
            begin
                if (REG_WE && chan_en_r[i])
                begin
                    if (REG_ADDR == `DDS_ADDR_CFUN)
                    begin
                        cfr_r[i] <= REG_WDATA[23:0];
                    end
                    if (REG_ADDR == `DDS_ADDR_FTW)
                    begin
                        ftw_s_r[i] <= REG_WDATA;
                    end
                    if (REG_ADDR == `DDS_ADDR_POW)
                    begin
                        pow_s_r[i] <= REG_WDATA[13:0];
                    end
                end
                // update strobe makes staged words active
                if (upd_take)
                begin
                    ftw_a_r[i] <= ftw_s_r[i];
                    pow_a_r[i] <= pow_s_r[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Phase datapath
    wire fifo_ready;
    assign go = fifo_ready;

    always @(posedge CLK)
    begin
        if (RESET)
        begin
            pipe_vld_r <= 1'b0;
            for (j = 0; j < 2; j = j + 1)
            begin
                acc_r[j] <= 32'h00000000;
                ph_r[j] <= 14'h0000;
                pow_d_r[j] <= `DDS_POW_RST;
            end
        end
        else if (go)
        begin
            pipe_vld_r <= 1'b1;
            for (j = 0; j < 2; j = j + 1)
            begin
                acc_r[j] <= acc_r[j] + ftw_a_r[j];
                pow_d_r[j] <= pow_a_r[j];
                // matched delay only in single tone
                if (cfr_r[j][`DDS_CF_MATCH] &&
                    cfr_r[j][`DDS_CF_KIND_HI:`DDS_CF_KIND_LO] ==
                    `DDS_KIND_NONE)
                begin
                    ph_r[j] <= acc_r[j][31:18] + pow_d_r[j];
                end
                else
                begin
                    ph_r[j] <= acc_r[j][31:18] + pow_a_r[j];
                end
            end
        end
    end

    assign push_data = {cos_code(ph_r[1]), cos_code(ph_r[0])};

    dds_fifo #(
        .WIDTH(20),
        .DEPTH(`DDS_FIFO_DEPTH),
        .AW(`DDS_FIFO_AW)
    ) u_fifo (
        .clk(CLK),
        .reset(RESET),
        .in_valid(pipe_vld_r),
        .in_ready(fifo_ready),
        .in_data(push_data),
        .out_valid(DAC_VALID),
        .out_ready(DAC_READY),
        .out_data({DAC1_CODE, DAC0_CODE})
    );

    ////////////////////////////////////////////////////////////////////////
    // Mode legality, ramp inputs and read-back
    always @*
    begin
        ramp_nxt = 2'h0;
        case (ramp_src_r)
            `DDS_SRC_P23:
                ramp_nxt = {prof_r[3], prof_r[2]};
            `DDS_SRC_P3:
                ramp_nxt = {prof_r[3], prof_r[3]};
            // lower two serial lines as ramp inputs
            `DDS_SRC_SDIO:
                ramp_nxt = {SDIO_RAMP_IN[1], SDIO_RAMP_IN[0]};
            default:
                ramp_nxt = 2'h0;
        endcase
        ramp_nxt = ramp_nxt & {cfr_r[1][`DDS_CF_RAMP], cfr_r[0][`DDS_CF_RAMP]};
    end

    assign rch = !chan_en_r[0];

    always @*
    begin
        rdata_nxt = 32'h00000000;
        case (REG_ADDR)
            `DDS_ADDR_CSEL:
                rdata_nxt = {24'h000000, chan_en_r, illegal_r, ramp_src_r,
                    sio_mode_r, 1'b0};
            `DDS_ADDR_CFUN:
                rdata_nxt = {8'h00, cfr_r[rch]};
            `DDS_ADDR_FTW:
                rdata_nxt = ftw_s_r[rch];
            `DDS_ADDR_POW:
                rdata_nxt = {18'h00000, pow_s_r[rch]};
            default:
                rdata_nxt = 32'h00000000;
        endcase
    end

    always @(posedge CLK)
    begin
        if (RESET)
        begin
            illegal_r <= 1'b0;
            ramp_r <= 2'h0;
            rdata_r <= 32'h00000000;
        end
        else
        begin
            illegal_r <= !(chan_ok(cfr_r[0], cfr_r[1], ramp_src_r) &&
                chan_ok(cfr_r[1], cfr_r[0], ramp_src_r));
            ramp_r <= ramp_nxt;
            if (REG_RE)
            begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    assign REG_RDATA = rdata_r;
    assign MODE_ILLEGAL = illegal_r;
    assign AMPLITUDE_RAMP = ramp_r;
    assign SERIAL_MODE = sio_mode_r;
endmodule // dds_core
`default_nettype wire

// file: src/dds_consts.vh
// Register map, field positions and reset values of the two-channel DDS core
`ifndef DDS_CONSTS_VH
`define DDS_CONSTS_VH
`define DDS_ADDR_CSEL 8'h00
`define DDS_ADDR_CFUN 8'h03
`define DDS_ADDR_FTW 8'h04
`define DDS_ADDR_POW 8'h05
`define DDS_CS_EN_HI 7
`define DDS_CS_EN_LO 6
`define DDS_CS_ERR 5
`define DDS_CS_SRC_HI 4
`define DDS_CS_SRC_LO 3
`define DDS_CS_SIO_HI 2
`define DDS_CS_SIO_LO 1
`define DDS_CS_EN_RST 2'h3
`define DDS_CS_SRC_RST 2'h0
`define DDS_CS_SIO_RST 2'h0
`define DDS_CF_KIND_HI 23
`define DDS_CF_KIND_LO 22
`define DDS_CF_MATCH 21
`define DDS_CF_LVL_HI 17
`define DDS_CF_LVL_LO 16
`define DDS_CF_SWEEP 15
`define DDS_CF_RAMP 14
`define DDS_CF_RST 24'h000000
`define DDS_KIND_NONE 2'h0
`define DDS_KIND_AMP 2'h1
`define DDS_LVL_2 2'h0
`define DDS_LVL_4 2'h1
`define DDS_LVL_8 2'h2
`define DDS_SRC_NONE 2'h0
`define DDS_SRC_P23 2'h1
`define DDS_SRC_P3 2'h2
`define DDS_SRC_SDIO 2'h3
`define DDS_FTW_RST 32'h00000000
`define DDS_POW_RST 14'h0000
`define DDS_SYNC_RST 2'h0
`define DDS_SYNC_SAMPLE 2'h1
`define DDS_QUARTER 14'h1000
`define DDS_MID 10'h200
`define DDS_FIFO_DEPTH 8
`define DDS_FIFO_AW 3
`endif

// file: sim/dds_properties.sv
// Port-level properties of the two-channel DDS core
`timescale 1ns/1ns
`default_nettype none
module dds_checker (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_RE,
    input wire logic [31:0] REG_RDATA,
    // Status and sample stream
    input wire logic SYNC_CLK,
    input wire logic MODE_ILLEGAL,
    input wire logic [1:0] AMPLITUDE_RAMP,
    input wire logic [1:0] SERIAL_MODE,
    input wire logic [9:0] DAC0_CODE,
    input wire logic [9:0] DAC1_CODE,
    input wire logic DAC_VALID,
    input wire logic DAC_READY
);
    default clocking cb @(posedge CLK); endclocking
    a_reset_idle: assert property (
        RESET |=> !DAC_VALID && !MODE_ILLEGAL && SERIAL_MODE == 2'h0)
        else $error("outputs not idle after reset");
    a_reset_sync: assert property (
        RESET |=> !SYNC_CLK && REG_RDATA == 32'h0 && AMPLITUDE_RAMP == 2'h0)
        else $error("sync clock or read data not cleared by reset");
    a_first_sample: assert property (
        disable iff (RESET) $fell(RESET) |-> ##[1:3] (DAC_VALID
        && DAC0_CODE == 10'h3FF && DAC1_CODE == 10'h3FF))
        else $error("first sample after reset is not full scale");
    a_sync_start: assert property (
        disable iff (RESET) $fell(RESET) |-> ##[1:4] $rose(SYNC_CLK))
        else $error("sync clock did not start after reset");
    a_sync_period: assert property (
        disable iff (RESET)
        $rose(SYNC_CLK) |-> ##2 $fell(SYNC_CLK) ##2 $rose(SYNC_CLK))
        else $error("sync clock is not a quarter of the clock");
    a_dac_hold: assert property (
        disable iff (RESET) DAC_VALID && !DAC_READY |=> DAC_VALID
        && $stable(DAC0_CODE) && $stable(DAC1_CODE))
        else $error("sample changed while sink stalled");
    a_unmapped_read: assert property (
        disable iff (RESET) REG_RE && REG_ADDR == 8'h01 |=> REG_RDATA == 32'h0)
        else $error("unmapped read returned nonzero");
    a_rdata_hold: assert property (
        disable iff (RESET) !REG_RE |=> $stable(REG_RDATA))
        else $error("read data changed without a read");
endmodule // dds_checker
`default_nettype wire

// file: sim/dds_host.sv
// Host model: update strobe, profile pins and sample sink
`timescale 1ns/1ns
`default_nettype none
module dds_host (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Requests from the bench
    input wire logic upd_req,
    input wire logic [3:0] prof_req,
    input wire logic sink_stall,
    // Pins toward the core
    input wire logic SYNC_CLK,
    output logic IO_UPDATE,
    output logic [3:0] PROFILE,
    output logic DAC_READY
);
    logic [2:0] hold_r;
    // strobe spans a full sync period
    assign IO_UPDATE = (hold_r != 3'h0);
    always @(posedge CLK)
    begin
        if (RESET)
        begin
            hold_r <= 3'h0;
            PROFILE <= 4'h0;
            DAC_READY <= 1'b0;
        end
        else
        begin
            if (upd_req)
                hold_r <= 3'h4;
            else if (hold_r != 3'h0)
                hold_r <= hold_r - 3'h1;
            // profile moves while the sync clock is low, up to the sync rise
            if (!SYNC_CLK)
                PROFILE <= prof_req;
            DAC_READY <= !sink_stall;
        end
    end
endmodule // dds_host
`default_nettype wire

// file: sim/dds_core_tb.sv
// Self-checking bench of the two-channel DDS core
`timescale 1ns/1ns
`default_nettype none
`include "dds_consts.vh"
module dds_core_tb;
    logic CLK, RESET, REG_WE, REG_RE, IO_UPDATE, SYNC_CLK, MODE_ILLEGAL;
    logic DAC_VALID, DAC_READY, upd_req, sink_stall;
    logic [7:0] REG_ADDR;
    logic [31:0] REG_WDATA, REG_RDATA, d;
    logic [3:0] PROFILE, prof_req;
    logic [2:0] SDIO_RAMP_IN;
    logic [1:0] AMPLITUDE_RAMP, SERIAL_MODE;
    logic [9:0] DAC0_CODE, DAC1_CODE;
    logic [9:0] s [0:15];
    int n_errors = 0;
    int n_checks = 0;
    dds_core uut (.CLK, .RESET, .REG_ADDR, .REG_WDATA, .REG_WE, .REG_RE,
        .REG_RDATA, .IO_UPDATE, .PROFILE, .SDIO_RAMP_IN, .SYNC_CLK,
        .MODE_ILLEGAL, .AMPLITUDE_RAMP, .SERIAL_MODE, .DAC0_CODE, .DAC1_CODE,
        .DAC_VALID, .DAC_READY);
    dds_host hst (.CLK, .RESET, .upd_req, .prof_req, .sink_stall, .SYNC_CLK,
        .IO_UPDATE, .PROFILE, .DAC_READY);
    initial
    begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    task conclude;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        cyc(1);
        REG_ADDR = a;
        REG_WDATA = v;
        REG_WE = 1'b1;
        cyc(1);
        REG_WE = 1'b0;
    endtask
    task rd(input logic [7:0] a);
        cyc(1);
        REG_ADDR = a;
        REG_RE = 1'b1;
        cyc(1);
        REG_RE = 1'b0;
        d = REG_RDATA;
    endtask
    task rst;
        RESET = 1'b1;
        cyc(12);
        RESET = 1'b0;
    endtask
    task upd;
        upd_req = 1'b1;
        cyc(1);
        upd_req = 1'b0;
        cyc(20);
    endtask
    task t_reset;
        rd(`DDS_ADDR_CSEL);
        chk("select", 32'h60, {25'h0, d[7:1]});
        chk("serial mode", 32'h0, {30'h0, SERIAL_MODE});
        rd(`DDS_ADDR_CFUN);
        chk("function", 32'h0, d);
        rd(`DDS_ADDR_FTW);
        chk("tuning", 32'h0, d);
        rd(`DDS_ADDR_POW);
        chk("offset", 32'h0, d);
        $display("test reset done");
    endtask
    task t_shared;
        wr(`DDS_ADDR_CSEL, 32'h46);
        chk("serial mode", 32'h3, {30'h0, SERIAL_MODE});
        wr(`DDS_ADDR_FTW, 32'h12345678);
        wr(`DDS_ADDR_CSEL, 32'h80);
        wr(`DDS_ADDR_FTW, 32'h0ABCDEF0);
        rd(`DDS_ADDR_FTW);
        chk("tuning ch1", 32'h0ABCDEF0, d);
        wr(`DDS_ADDR_CSEL, 32'h40);
        rd(`DDS_ADDR_FTW);
        chk("tuning ch0", 32'h12345678, d);
        wr(`DDS_ADDR_POW, 32'hFFFFFFFF);
        rd(`DDS_ADDR_POW);
        chk("offset width", 32'h3FFF, d);
        wr(8'h01, 32'hFFFFFFFF);
        rd(8'h01);
        chk("unmapped", 32'h0, d);
        $display("test shared done");
    endtask
    task t_phase;
        wr(`DDS_ADDR_FTW, 32'h0);
        wr(`DDS_ADDR_POW, 32'h1000);
        wr(`DDS_ADDR_CSEL, 32'h80);
        wr(`DDS_ADDR_FTW, 32'h0);
        wr(`DDS_ADDR_POW, 32'h0);
        wr(`DDS_ADDR_CSEL, 32'hC0);
        cyc(20);
        chk("staged dac0", 32'h3FF, DAC0_CODE);
        upd;
        chk("offset dac0", 32'h200, DAC0_CODE);
        chk("offset dac1", 32'h3FF, DAC1_CODE);
        $display("test phase done");
    endtask
    task t_stream;
        int k;
        wr(`DDS_ADDR_FTW, 32'h40000000);
        wr(`DDS_ADDR_POW, 32'h0);
        upd;
        for (int i = 0; i < 16; i++)
        begin
            k = 0;
            while (!(DAC_VALID && DAC_READY) && k < 40)
            begin
                cyc(1);
                k++;
            end
            if (k == 40)
            begin
                n_errors++;
                $display("BAD sample wait expected 1 seen 0");
                conclude;
            end
            s[i] = DAC0_CODE;
            chk("channel match", {22'h0, s[i]}, DAC1_CODE);
            // Stall rises with the pop of this sample so none is skipped
            if (i == 6)
                sink_stall = 1'b1;
            cyc(1);
            if (i == 6)
            begin
                cyc(15);
                sink_stall = 1'b0;
                cyc(1);
            end
        end
        for (int i = 0; i < 12; i++)
            chk("period four", {22'h0, s[i]}, s[i+4]);
        for (int i = 0; i < 14; i++)
            chk("half period", 32'h400, s[i] + s[i+2]);
        $display("test stream done");
    endtask
    task mode(input [1:0] src, input [23:0] c0, input [23:0] c1, input e);
        wr(`DDS_ADDR_CSEL, {24'h0, 3'b010, src, 3'b000});
        wr(`DDS_ADDR_CFUN, {8'h0, c0});
        wr(`DDS_ADDR_CSEL, {24'h0, 3'b100, src, 3'b000});
        wr(`DDS_ADDR_CFUN, {8'h0, c1});
        wr(`DDS_ADDR_CSEL, {24'h0, 3'b110, src, 3'b000});
        cyc(4);
        chk("illegal", {31'h0, e}, MODE_ILLEGAL);
    endtask
    task t_match;
        int n;
        wr(`DDS_ADDR_FTW, 32'h0);
        wr(`DDS_ADDR_POW, 32'h0);
        upd;
        wr(`DDS_ADDR_POW, 32'h1000);
        wr(`DDS_ADDR_CSEL, 32'h40);
        wr(`DDS_ADDR_CFUN, 32'h200000);
        wr(`DDS_ADDR_CSEL, 32'hC0);
        n = 0;
        upd_req = 1'b1;
        cyc(1);
        upd_req = 1'b0;
        // Channel 0 takes the new offset one sample after channel 1
        for (int i = 0; i < 32; i++)
        begin
            if (DAC_VALID && DAC_READY && DAC0_CODE != DAC1_CODE)
                n++;
            cyc(1);
        end
        chk("matched delay skew", 32'h1, n);
        $display("test match done");
    endtask
    task t_modes;
        mode(2'h0, 24'h820000, 24'h0, 1'b0);
        mode(2'h0, 24'h820000, 24'h820000, 1'b1);
        mode(2'h0, 24'h810000, 24'h810000, 1'b0);
        mode(2'h0, 24'h808000, 24'h800000, 1'b0);
        mode(2'h3, 24'h404000, 24'h0, 1'b1);
        mode(2'h3, 24'h814000, 24'h814000, 1'b0);
        mode(2'h3, 24'h834000, 24'h0, 1'b0);
        mode(2'h1, 24'h804000, 24'h0, 1'b0);
        mode(2'h1, 24'h80C000, 24'h80C000, 1'b0);
        mode(2'h2, 24'h824000, 24'h0, 1'b0);
        mode(2'h3, 24'h004000, 24'h004000, 1'b0);
        SDIO_RAMP_IN = 3'b010;
        cyc(4);
        chk("serial ramp", 32'h2, AMPLITUDE_RAMP);
        mode(2'h2, 24'h004000, 24'h004000, 1'b0);
        prof_req = 4'h8;
        cyc(12);
        chk("profile ramp", 32'h3, AMPLITUDE_RAMP);
        prof_req = 4'h0;
        mode(2'h0, 24'h0, 24'h0, 1'b0);
        $display("test modes done");
    endtask
    initial
    begin
        {REG_WE, REG_RE, upd_req, sink_stall} = 4'h0;
        REG_ADDR = 8'h00;
        REG_WDATA = 32'h0;
        prof_req = 4'h0;
        SDIO_RAMP_IN = 3'h0;
        #1;
        rst;
        t_reset;
        t_shared;
        t_phase;
        t_stream;
        t_modes;
        t_match;
        rst;
        t_reset;
        conclude;
    end
endmodule // dds_core_tb
bind dds_core dds_checker chk_i (.CLK, .RESET, .REG_ADDR, .REG_RE,
    .REG_RDATA, .SYNC_CLK, .MODE_ILLEGAL, .AMPLITUDE_RAMP, .SERIAL_MODE,
    .DAC0_CODE, .DAC1_CODE, .DAC_VALID, .DAC_READY);
`default_nettype wire
